// *** src/icc_pkg.sv ***
package icc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int          CH_MAX      = 8;
  localparam int          DATA_W      = 16;
  localparam int          FIFO_DEPTH  = 4;
  localparam logic [2:0]  FIFO_FULL   = 3'h4;
  localparam int          ADDR_W      = 4;

  // ---------------------------------------------------------------------------
  // Register map, word addresses: bits 3:1 pick the channel, bit 0 the register
  // ---------------------------------------------------------------------------
  localparam logic        SEL_CTRL    = 1'b0;
  localparam logic        SEL_BUF     = 1'b1;

  // ---------------------------------------------------------------------------
  // Channel control register fields
  // ---------------------------------------------------------------------------
  localparam int          MODE_LSB    = 0;
  localparam int          BNE_BIT     = 3;
  localparam int          OV_BIT      = 4;
  localparam int          CPI_LSB     = 5;
  localparam int          TSEL_BIT    = 7;
  localparam logic [2:0]  MODE_RESET  = 3'h0;
  localparam logic [1:0]  CPI_RESET   = 2'h0;
  localparam logic        TSEL_RESET  = 1'b0;

  // ---------------------------------------------------------------------------
  // Capture modes
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  MODE_OFF    = 3'h0;
  localparam logic [2:0]  MODE_BOTH   = 3'h1;
  localparam logic [2:0]  MODE_FALL   = 3'h2;
  localparam logic [2:0]  MODE_RISE   = 3'h3;
  localparam logic [2:0]  MODE_RISE4  = 3'h4;
  localparam logic [2:0]  MODE_RISE16 = 3'h5;
  localparam logic [2:0]  MODE_IRQ    = 3'h7;

  // ---------------------------------------------------------------------------
  // Prescaler terminal counts
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  PRESC_LAST4  = 4'h3;
  localparam logic [3:0]  PRESC_LAST16 = 4'hf;

endpackage

// *** src/icc_top.sv ***
// Contract
// - Capture modes: every falling, every rising, every rising and falling edge.
// - Prescaled modes capture every 4th or 16th rising edge via prescaler counter.
// - Prescaler counter clears while the mode field says off.
// - Reset clears each channel prescaler counter.
// - Each channel has a four entry, 16-bit capture buffer.
// - Not-empty flag set on first capture, held until all entries read.
// - A buffer read returns the oldest entry and shifts the rest forward.
// - Fifth capture into a full buffer sets the overflow flag.
// - Overflowing capture is discarded; stored entries stay unchanged.
// - After overflow, captures are ignored until the buffer is read empty.
// - Control bit seven selects which of two timers is the time base.
// - Time-select zero, the reset value, uses the second timer.
// - Every-edge mode raises the interrupt flag on each rising and falling edge.
// - Every-edge mode ignores captures-per-interrupt; each capture interrupts.
// - Every-edge mode never sets the overflow flag.
// - Captures-per-interrupt field, bits six to five, sets captures per interrupt.
// - Mode all ones: rising-edge interrupt only, wakes device when enabled.
`timescale 1ns/1ps

module icc_top
  import icc_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire logic [NUM_CH-1:0]   capture_pin,
  input  wire logic [NUM_CH-1:0]   interrupt_enable,
  input  wire logic [DATA_W-1:0]   first_time_base,
  input  wire logic [DATA_W-1:0]   second_time_base,
  output logic      [NUM_CH-1:0]   channel_interrupt_flag,
  output logic      [NUM_CH-1:0]   wake_request
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [NUM_CH-1:0]  sync1_ff, sync2_ff, sync3_ff, level_ff;
  logic [NUM_CH-1:0]  nxt_level;
  logic [2:0]         mode_ff      [NUM_CH];
  logic [2:0]         nxt_mode     [NUM_CH];
  logic [1:0]         cpi_ff       [NUM_CH];
  logic [1:0]         nxt_cpi      [NUM_CH];
  logic [NUM_CH-1:0]  tsel_ff, nxt_tsel;
  logic [NUM_CH-1:0]  ov_ff, nxt_ov;
  logic [NUM_CH-1:0]  lock_ff, nxt_lock;
  logic [3:0]         presc_ff     [NUM_CH];
  logic [3:0]         nxt_presc    [NUM_CH];
  logic [1:0]         icnt_ff      [NUM_CH];
  logic [1:0]         nxt_icnt     [NUM_CH];
  logic [2:0]         cnt_ff       [NUM_CH];
  logic [2:0]         nxt_cnt      [NUM_CH];
  logic [DATA_W-1:0]  fifo_ff      [NUM_CH][FIFO_DEPTH];
  logic [DATA_W-1:0]  nxt_fifo     [NUM_CH][FIFO_DEPTH];
  logic [NUM_CH-1:0]  irq_ff, nxt_irq;
  logic [NUM_CH-1:0]  wake_ff, nxt_wake;
  logic               wait_ff, nxt_wait;
  logic [31:0]        rdata_ff, nxt_rdata;

  // Access completes on the edge where the master sees waitrequest low.
  logic               do_read, do_write;
  logic [2:0]         bus_ch;

  assign do_read  = read && !wait_ff;
  assign do_write = write && !wait_ff;
  assign bus_ch   = address[3:1];

  function automatic logic sel_hit(input logic [2:0] ch, input int c, input logic sel,
                                   input logic want);
    sel_hit = (ch == 3'(c)) && (sel == want);
  endfunction

  // Every-edge mode drops a capture into a full buffer silently instead of flagging it.
  function automatic logic overflows(input logic capt, input logic full, input logic pop,
                                     input logic [2:0] mode);
    overflows = capt && full && !pop && (mode != MODE_BOTH);
  endfunction

  // ---------------------------------------------------------------------------
  // Bus slave: one wait state on every access
  // ---------------------------------------------------------------------------
  always_comb begin
    int c;
    c         = 0;
    nxt_wait  = !((read || write) && wait_ff);
    nxt_rdata = rdata_ff;
    if ((read || write) && wait_ff) begin
      nxt_rdata = 32'h0000_0000;
      for (c = 0; c < NUM_CH; c++) begin
        if (sel_hit(bus_ch, c, address[0], SEL_CTRL)) begin
          nxt_rdata[MODE_LSB+:3] = mode_ff[c];
          nxt_rdata[BNE_BIT]     = (cnt_ff[c] != 3'h0);
          nxt_rdata[OV_BIT]      = ov_ff[c];
          nxt_rdata[CPI_LSB+:2]  = cpi_ff[c];
          nxt_rdata[TSEL_BIT]    = tsel_ff[c];
        end else if (sel_hit(bus_ch, c, address[0], SEL_BUF)) begin
          // An empty buffer returns stale head data; no pop follows.
          nxt_rdata[DATA_W-1:0] = fifo_ff[c][0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------------------
  // Only the second stage reads the first; the second and third together qualify a change.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= capture_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------------------
  always_comb begin
    logic             rise, fall, ev, capt, store, pop, full, irq_ev, ovf;
    logic [2:0]       pos;
    logic [DATA_W-1:0] stamp;
    rise  = 1'b0;
    fall  = 1'b0;
    ev    = 1'b0;
    capt  = 1'b0;
    store = 1'b0;
    pop   = 1'b0;
    full  = 1'b0;
    irq_ev = 1'b0;
    ovf   = 1'b0;
    pos   = 3'h0;
    stamp = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      nxt_level[c] = level_ff[c];
      nxt_mode[c]  = mode_ff[c];
      nxt_cpi[c]   = cpi_ff[c];
      nxt_tsel[c]  = tsel_ff[c];
      nxt_ov[c]    = ov_ff[c];
      nxt_lock[c]  = lock_ff[c];
      nxt_presc[c] = presc_ff[c];
      nxt_icnt[c]  = icnt_ff[c];
      nxt_cnt[c]   = cnt_ff[c];
      nxt_irq[c]   = 1'b0;
      nxt_wake[c]  = 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        nxt_fifo[c][i] = fifo_ff[c][i];
      end

      // A pin change counts only once the last two stages agree.
      if (sync2_ff[c] == sync3_ff[c]) begin
        nxt_level[c] = sync3_ff[c];
      end
      rise = (sync2_ff[c] == sync3_ff[c]) && sync3_ff[c] && !level_ff[c];
      fall = (sync2_ff[c] == sync3_ff[c]) && !sync3_ff[c] && level_ff[c];

      case (mode_ff[c])
        MODE_BOTH:   ev = rise || fall;
        MODE_FALL:   ev = fall;
        MODE_RISE:   ev = rise;
        MODE_RISE4:  ev = rise && (presc_ff[c] == PRESC_LAST4);
        MODE_RISE16: ev = rise && (presc_ff[c] == PRESC_LAST16);
        MODE_IRQ:    ev = rise;
        default:     ev = 1'b0;
      endcase

      if (mode_ff[c] == MODE_OFF) begin
        nxt_presc[c] = 4'h0;
      end else if ((mode_ff[c] == MODE_RISE4 || mode_ff[c] == MODE_RISE16) && rise) begin
        nxt_presc[c] = ev ? 4'h0 : 4'(presc_ff[c] + 4'h1);
      end

      // A read of an empty buffer pops nothing, so the count cannot wrap below zero.
      pop   = do_read && sel_hit(bus_ch, c, address[0], SEL_BUF) && (cnt_ff[c] != 3'h0);
      full  = (cnt_ff[c] == FIFO_FULL);
      capt  = ev && (mode_ff[c] != MODE_IRQ) && !lock_ff[c];
      store = capt && (!full || pop);
      ovf   = overflows(capt, full, pop, mode_ff[c]);
      if (ovf) begin
        nxt_ov[c]   = 1'b1;
        nxt_lock[c] = 1'b1;
      end

      // Both time bases run on this clock, so the count is taken without a crossing.
      stamp = tsel_ff[c] ? first_time_base : second_time_base;
      if (pop) begin
        for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
          nxt_fifo[c][i] = fifo_ff[c][i+1];
        end
      end
      pos = 3'(cnt_ff[c] - {2'h0, pop});
      if (store) begin
        nxt_fifo[c][pos[1:0]] = stamp;
      end
      nxt_cnt[c] = 3'(cnt_ff[c] - {2'h0, pop} + {2'h0, store});
      // The lock outlives the overflow flag, since software may clear the flag before draining.
      if (nxt_cnt[c] == 3'h0) begin
        nxt_lock[c] = 1'b0;
      end

      // Every-edge mode interrupts on each edge, even one whose capture a full buffer drops.
      irq_ev = store || (ev && (mode_ff[c] == MODE_IRQ || mode_ff[c] == MODE_BOTH));
      if (mode_ff[c] == MODE_OFF) begin
        nxt_icnt[c] = 2'h0;
      end else if (irq_ev && (mode_ff[c] == MODE_BOTH || mode_ff[c] == MODE_IRQ)) begin
        nxt_irq[c] = 1'b1;
      end else if (irq_ev) begin
        if (icnt_ff[c] == cpi_ff[c]) begin
          nxt_irq[c]  = 1'b1;
          nxt_icnt[c] = 2'h0;
        end else begin
          nxt_icnt[c] = 2'(icnt_ff[c] + 2'h1);
        end
      end
      nxt_wake[c] = (mode_ff[c] == MODE_IRQ) && rise && interrupt_enable[c];

      // Only lane 0 carries control bits; a write without it leaves the channel alone.
      if (do_write && byteenable[0] && sel_hit(bus_ch, c, address[0], SEL_CTRL)) begin
        nxt_mode[c] = writedata[MODE_LSB+:3];
        nxt_cpi[c]  = writedata[CPI_LSB+:2];
        nxt_tsel[c] = writedata[TSEL_BIT];
        // Writing zero clears overflow, but a new overflow in the same cycle wins.
        if (!writedata[OV_BIT] && !ovf) begin
          nxt_ov[c] = 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Channel registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      level_ff    <= '0;
      tsel_ff     <= {NUM_CH{TSEL_RESET}};
      ov_ff       <= '0;
      lock_ff     <= '0;
      irq_ff      <= '0;
      wake_ff     <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        mode_ff[c]  <= MODE_RESET;
        cpi_ff[c]   <= CPI_RESET;
        presc_ff[c] <= 4'h0;
        icnt_ff[c]  <= 2'h0;
        cnt_ff[c]   <= 3'h0;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
          fifo_ff[c][i] <= '0;
        end
      end
    end else begin
      level_ff    <= nxt_level;
      tsel_ff     <= nxt_tsel;
      ov_ff       <= nxt_ov;
      lock_ff     <= nxt_lock;
      irq_ff      <= nxt_irq;
      wake_ff     <= nxt_wake;
      for (int c = 0; c < NUM_CH; c++) begin
        mode_ff[c]  <= nxt_mode[c];
        cpi_ff[c]   <= nxt_cpi[c];
        presc_ff[c] <= nxt_presc[c];
        icnt_ff[c]  <= nxt_icnt[c];
        cnt_ff[c]   <= nxt_cnt[c];
        for (int i = 0; i < FIFO_DEPTH; i++) begin
          fifo_ff[c][i] <= nxt_fifo[c][i];
        end
      end
    end
  end

  assign readdata               = rdata_ff;
  assign waitrequest            = wait_ff;
  assign channel_interrupt_flag = irq_ff;
  assign wake_request           = wake_ff;

endmodule

// *** verif/icc_pin_src.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Sensor stand-in driving one capture pin
// -----------------------------------------------------------------------------
module icc_pin_src (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;
  // High four cycles, low six: wider than the three-flop synchroniser needs.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** verif/icc_top_asserts.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Port checks; pin-side checks look at channel 0, the one the bench's mode table exercises
// -----------------------------------------------------------------------------
module icc_top_asserts
  import icc_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  input wire logic [NUM_CH-1:0] capture_pin,
  input wire logic [NUM_CH-1:0] interrupt_enable,
  input wire logic [NUM_CH-1:0] channel_interrupt_flag,
  input wire logic [NUM_CH-1:0] wake_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("wait release longer than one cycle");
  a_wait_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without a request");
  a_reset_clean: assert property ($rose(nrst) |-> waitrequest && readdata == 32'h0
    && channel_interrupt_flag == '0 && wake_request == '0) else $error("reset state wrong");
  a_read_hold: assert property ($rose(waitrequest) |-> $stable(readdata))
    else $error("read data moved without access");
  a_unmapped_zero: assert property (read && waitrequest && address[ADDR_W-1:1] >= NUM_CH
    |=> readdata == 32'h0) else $error("unmapped channel read not zero");
  a_irq_pulse: assert property ((channel_interrupt_flag & $past(channel_interrupt_flag)) == '0)
    else $error("interrupt pulse longer than one cycle");
  a_wake_enabled: assert property ((wake_request & ~$past(interrupt_enable)) == '0)
    else $error("wake without enable");
  a_wake_cause: assert property ($rose(wake_request[0]) |-> $past(capture_pin[0], 2)
    || $past(capture_pin[0], 3) || $past(capture_pin[0], 4) || $past(capture_pin[0], 5)
    || $past(capture_pin[0], 6)) else $error("wake without a rising pin");
  c_irq: cover property (channel_interrupt_flag[0]);
  c_wake: cover property (wake_request[0]);
  c_buf_read: cover property (read && !waitrequest && address[0]);
endmodule
bind icc_top icc_top_asserts #(.NUM_CH(NUM_CH)) i_chk (
  .clk, .nrst, .address, .read, .write, .readdata, .waitrequest, .capture_pin,
  .interrupt_enable, .channel_interrupt_flag, .wake_request
);

// *** verif/input_capture_channels_test.sv ***
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Bench: table of capture modes on channel 0, then hand-written edge cases
// -----------------------------------------------------------------------------
module input_capture_channels_test;
  import icc_pkg::*;
  typedef struct {
    logic [2:0] m;
    logic       ts, ov;
    logic [1:0] cpi;
    int         np, ncap, nirq, sa, sb;
  } icc_row_t;
  logic        clk, nrst, read, write, waitrequest, pin0, pin1;
  logic [1:0]  pin_up;
  logic [3:0]  address, irq, wake, be, ien;
  logic [31:0] writedata, readdata, q;
  logic [11:0] cnt, pv, d;
  logic [15:0] tb1, tb2;
  int          fail_count, samples_checked, irqs, irq1s, wakes, i0, i1, w0, k;
  // Fields: mode, select, overflow, per-interrupt, pulses, stored, irqs, steps.
  icc_row_t rows [8] = '{
    '{MODE_RISE, 1'h0, 1'h0, 2'h0, 3, 3, 3, 10, 10},
    '{MODE_FALL, 1'h1, 1'h0, 2'h1, 4, 4, 2, 10, 10},
    '{MODE_BOTH, 1'h0, 1'h0, 2'h3, 3, 4, 6, 4, 6},
    '{MODE_RISE4, 1'h1, 1'h0, 2'h0, 9, 2, 2, 40, 40},
    '{MODE_RISE16, 1'h0, 1'h0, 2'h0, 17, 1, 1, 0, 0},
    '{MODE_RISE, 1'h0, 1'h1, 2'h0, 6, 4, 4, 10, 10},
    '{3'h6, 1'h0, 1'h0, 2'h0, 2, 0, 0, 0, 0},
    '{MODE_IRQ, 1'h0, 1'h0, 2'h0, 2, -1, 2, 0, 0}};
  assign tb1 = {4'h1, cnt};
  assign tb2 = {4'h2, cnt};
  icc_top i_dut (.clk, .nrst, .address, .read, .write, .writedata, .byteenable(be),
    .readdata, .waitrequest, .capture_pin({pin_up, pin1, pin0}), .interrupt_enable(ien),
    .first_time_base(tb1), .second_time_base(tb2),
    .channel_interrupt_flag(irq), .wake_request(wake));
  icc_pin_src i_src (.clk(clk), .pin(pin0));
  icc_pin_src i_src1 (.clk(clk), .pin(pin1));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt <= cnt + 12'h1;
    irqs <= irqs + int'(irq[0]);
    irq1s <= irq1s + int'(irq[1]);
    wakes <= wakes + int'(wake[0]);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= dt;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  // Reads the buffer only while not-empty is set, since an empty read returns only stale head data.
  task automatic pop_all(input logic [3:0] hi, input int sa, input int sb);
    k = 0;
    bus(1'b0, 4'h0, 32'h0);
    while (q[BNE_BIT] === 1'b1 && k < 6) begin
      bus(1'b0, 4'h1, 32'h0);
      d = q[11:0] - pv;
      if (hi != 4'h0) chk(q[15:12], hi);
      if (k > 0 && sa > 0) chk(d, (k % 2) ? sa : sb);
      pv = q[11:0];
      k++;
      bus(1'b0, 4'h0, 32'h0);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #250000;
    fail_count++;
    end_sim;
  end
  initial begin
    {nrst, read, write, address, writedata, cnt, pv, irqs, wakes} = '0;
    {fail_count, samples_checked, irq1s} = '0;
    {pin_up, be, ien} = {2'h0, 4'hf, 4'h1};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 4'h6, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h9, 32'h0);
    chk(q, 32'h0);
    $display("reset values done");
    foreach (rows[i]) begin
      bus(1'b1, 4'h0, 32'h0);
      pop_all(4'h0, 0, 0);
      bus(1'b1, 4'h0, 32'({rows[i].ts, rows[i].cpi, 2'h0, rows[i].m}));
      i0 = irqs;
      w0 = wakes;
      i_src.pulses(rows[i].np);
      bus(1'b0, 4'h0, 32'h0);
      chk(q[OV_BIT], rows[i].ov);
      chk(irqs - i0, rows[i].nirq);
      chk(wakes - w0, (rows[i].m == MODE_IRQ) ? rows[i].np : 0);
      pop_all(rows[i].ts ? 4'h1 : 4'h2, rows[i].sa, rows[i].sb);
      if (rows[i].ncap >= 0) chk(k, rows[i].ncap);
      $display("row %0d done", i);
    end
    bus(1'b1, 4'h0, 32'(MODE_RISE4));
    i_src.pulses(3);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'(MODE_RISE4));
    i_src.pulses(1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q[BNE_BIT], 1'b0);
    i_src.pulses(5);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h0, 32'(MODE_RISE4));
    i_src.pulses(3);
    bus(1'b0, 4'h0, 32'h0);
    chk(q[BNE_BIT], 1'b0);
    $display("prescaler clear done");
    bus(1'b1, 4'h0, 32'(MODE_RISE));
    i_src.pulses(5);
    repeat (2) bus(1'b0, 4'h1, 32'h0);
    i_src.pulses(1);
    repeat (2) bus(1'b0, 4'h1, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(q[BNE_BIT], 1'b0);
    chk(q[OV_BIT], 1'b1);
    i_src.pulses(1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q[BNE_BIT], 1'b1);
    $display("overflow lock done");
    be <= 4'he;
    bus(1'b1, 4'h0, 32'(MODE_OFF));
    be <= 4'hf;
    bus(1'b0, 4'h0, 32'h0);
    chk(q[2:0], MODE_RISE);
    chk(q[OV_BIT], 1'b1);
    ien <= 4'h0;
    bus(1'b1, 4'h0, 32'(MODE_IRQ));
    i0 = irqs;
    w0 = wakes;
    i_src.pulses(2);
    chk(irqs - i0, 2);
    chk(wakes - w0, 0);
    ien <= 4'h1;
    i0 = irqs;
    i1 = irq1s;
    bus(1'b1, 4'h2, 32'({1'b1, 4'h0, MODE_RISE}));
    i_src1.pulses(2);
    bus(1'b0, 4'h2, 32'h0);
    chk(q[BNE_BIT], 1'b1);
    bus(1'b0, 4'h3, 32'h0);
    chk(q[15:12], 4'h1);
    chk(irq1s - i1, 2);
    chk(irqs - i0, 0);
    $display("lane mask and second channel done");
    end_sim;
  end
endmodule
